// *** hdl/atten_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module atten_host (
   input  wire logic          CLK,
   input  wire logic          RST_B,
   input  wire logic          PSEL,
   input  wire logic          PENABLE,
   input  wire logic          PWRITE,
   input  wire logic [11:0]   PADDR,
   input  wire logic [31:0]   PWDATA,
   output logic [31:0]        PRDATA,
   output logic               PREADY,
   output logic               PSLVERR,
   atten_link_if.host         LINK
);

   logic [31:0]               prdata_q;
   logic                      pready_q;
   logic                      pslverr_q;
   logic [3:0]                ctrl_q;
   logic [5:0]                word_q;
   logic [5:0]                par_q;
   logic [3:0]                cnt_q;
   logic [2:0]                bit_q;
   logic                      sclk_q;
   logic                      sdata_q;
   logic                      le_q;
   atten_pkg::seq_state_type  state_q;
   logic                      busy;
   logic                      wr_fire;
   logic                      start;
   logic                      mapped;

   assign busy    = (state_q != atten_pkg::SEQ_IDLE);
   assign mapped  = (PADDR == atten_pkg::REG_CTRL) || (PADDR == atten_pkg::REG_DATA) ||
                    (PADDR == atten_pkg::REG_STATUS);
   // writes land on the edge where the master sees pready high
   assign wr_fire = PSEL && PENABLE && PWRITE && pready_q && !busy;
   assign start   = wr_fire && (PADDR == atten_pkg::REG_DATA);

   // apb answer: one wait state, read data registered
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h00000000;
      end else begin
         pready_q  <= PSEL && PENABLE && !pready_q;
         pslverr_q <= PSEL && PENABLE && !pready_q && !mapped;
         prdata_q  <= 32'h00000000;
         if (PSEL && PENABLE && !pready_q && !PWRITE) begin
            if (PADDR == atten_pkg::REG_CTRL) begin
               prdata_q <= {28'h0000000, ctrl_q};
            end else if (PADDR == atten_pkg::REG_DATA) begin
               prdata_q <= {26'h0000000, par_q};
            end else if (PADDR == atten_pkg::REG_STATUS) begin
               prdata_q <= {18'h00000, word_q, 7'h00, busy};
            end
         end
      end
   end

   // control register; refused while a transfer runs
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         ctrl_q <= atten_pkg::CTRL_RESET;
      end else if (wr_fire && (PADDR == atten_pkg::REG_CTRL)) begin
         ctrl_q <= PWDATA[3:0];
      end
   end

   // link sequencer; serial clock is CLK divided, data moves
   // mid-low so both setup and hold keep half a low phase
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         state_q <= atten_pkg::SEQ_IDLE;
         cnt_q   <= 4'h0;
         bit_q   <= 3'h0;
         sclk_q  <= 1'b0;
         sdata_q <= 1'b0;
         le_q    <= 1'b0;
         word_q  <= atten_pkg::ATTEN_REF;
         par_q   <= atten_pkg::ATTEN_REF;
      end else begin
         unique case (state_q)
            atten_pkg::SEQ_IDLE: begin
               sclk_q <= 1'b0;
               le_q   <= ctrl_q[atten_pkg::CTRL_DIRECT];
               if (start) begin
                  word_q <= PWDATA[5:0];
                  if (ctrl_q[atten_pkg::CTRL_SEL]) begin
                     sdata_q <= PWDATA[5];
                     bit_q   <= atten_pkg::MSB_INDEX;
                     cnt_q   <= atten_pkg::HALF_CYC - 4'h1;
                     state_q <= atten_pkg::SEQ_SHIFT;
                  end else begin
                     par_q <= PWDATA[5:0];
                     if (!ctrl_q[atten_pkg::CTRL_DIRECT]) begin
                        cnt_q   <= atten_pkg::SETUP_CYC - 4'h1;
                        state_q <= atten_pkg::SEQ_SETUP;
                     end
                  end
               end
            end
            atten_pkg::SEQ_SHIFT: begin
               if (cnt_q != 4'h0) begin
                  cnt_q <= cnt_q - 4'h1;
                  if (!sclk_q && (cnt_q == 4'h1)) begin
                     sdata_q <= word_q[bit_q];
                  end
               end else begin
                  cnt_q <= atten_pkg::HALF_CYC - 4'h1;
                  if (!sclk_q) begin
                     sclk_q <= 1'b1;
                  end else begin
                     sclk_q <= 1'b0;
                     if (bit_q == 3'h0) begin
                        cnt_q   <= atten_pkg::SETUP_CYC - 4'h1;
                        state_q <= atten_pkg::SEQ_SETUP;
                     end else begin
                        bit_q <= bit_q - 3'h1;
                     end
                  end
               end
            end
            atten_pkg::SEQ_SETUP: begin
               le_q <= 1'b0;
               if (cnt_q == 4'h0) begin
                  le_q    <= 1'b1;
                  cnt_q   <= atten_pkg::PW_CYC - 4'h1;
                  state_q <= atten_pkg::SEQ_STROBE;
               end else begin
                  cnt_q <= cnt_q - 4'h1;
               end
            end
            atten_pkg::SEQ_STROBE: begin
               if (cnt_q == 4'h0) begin
                  le_q    <= 1'b0;
                  cnt_q   <= atten_pkg::HOLD_CYC - 4'h1;
                  state_q <= atten_pkg::SEQ_HOLD;
               end else begin
                  cnt_q <= cnt_q - 4'h1;
               end
            end
            atten_pkg::SEQ_HOLD: begin
               if (cnt_q == 4'h0) begin
                  state_q <= atten_pkg::SEQ_IDLE;
               end else begin
                  cnt_q <= cnt_q - 4'h1;
               end
            end
            default: state_q <= atten_pkg::SEQ_IDLE;
         endcase
      end
   end

   // pins and bus outputs, all from flops
   assign LINK.serial_clk        = sclk_q;
   assign LINK.serial_data       = sdata_q;
   assign LINK.latch_strobe      = le_q;
   assign LINK.interface_select  = ctrl_q[atten_pkg::CTRL_SEL];
   assign LINK.powerup_sel_lo    = ctrl_q[atten_pkg::CTRL_PUP_LO];
   assign LINK.powerup_sel_hi    = ctrl_q[atten_pkg::CTRL_PUP_HI];
   assign LINK.atten_bit_16db    = par_q[5];
   assign LINK.atten_bit_8db     = par_q[4];
   assign LINK.atten_bit_4db     = par_q[3];
   assign LINK.atten_bit_2db     = par_q[2];
   assign LINK.atten_bit_1db     = par_q[1];
   assign LINK.atten_bit_half_db = par_q[0];
   assign PRDATA                 = prdata_q;
   assign PREADY                 = pready_q;
   assign PSLVERR                = pslverr_q;

endmodule
`default_nettype wire

// *** hdl/atten_pkg.sv ***
`default_nettype none
package atten_pkg;
   // attenuation word, one lsb is 0.5 dB
   localparam int            WORD_W      = 6;
   localparam logic [2:0]    MSB_INDEX   = 3'h5;
   localparam logic [5:0]    ATTEN_REF   = 6'h00;
   localparam logic [5:0]    PUP_8DB     = 6'h10;
   localparam logic [5:0]    PUP_16DB    = 6'h20;
   localparam logic [5:0]    PUP_31DB    = 6'h3e;

   // timing, host side
   localparam int            CLK_NS       = 25;
   localparam int            SCLK_HALF_NS = 50;
   localparam int            LE_SETUP_NS  = 10;
   localparam int            LE_PW_NS     = 30;
   localparam int            DATA_HOLD_NS = 10;
   localparam logic [3:0]    HALF_CYC  = 4'((SCLK_HALF_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0]    SETUP_CYC = 4'((LE_SETUP_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0]    PW_CYC    = 4'((LE_PW_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0]    HOLD_CYC  = 4'((DATA_HOLD_NS + CLK_NS - 1) / CLK_NS);

   // host registers
   localparam logic [11:0]   REG_CTRL    = 12'h000;
   localparam logic [11:0]   REG_DATA    = 12'h004;
   localparam logic [11:0]   REG_STATUS  = 12'h008;
   localparam int            CTRL_SEL    = 0;
   localparam int            CTRL_DIRECT = 1;
   localparam int            CTRL_PUP_LO = 2;
   localparam int            CTRL_PUP_HI = 3;
   localparam logic [3:0]    CTRL_RESET  = 4'h0;
   localparam int            STAT_BUSY   = 0;
   localparam int            STAT_WORD   = 8;

   typedef enum logic [1:0] {
      INIT_WAIT0 = 2'b00,
      INIT_WAIT1 = 2'b01,
      INIT_LOAD  = 2'b11,
      INIT_RUN   = 2'b10
   } init_state_type;

   typedef enum logic [2:0] {
      SEQ_IDLE   = 3'b000,
      SEQ_SHIFT  = 3'b001,
      SEQ_SETUP  = 3'b011,
      SEQ_STROBE = 3'b010,
      SEQ_HOLD   = 3'b110
   } seq_state_type;
endpackage
`default_nettype wire

// *** hdl/atten_link_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface atten_link_if;
   logic serial_clk;
   logic serial_data;
   logic latch_strobe;
   logic interface_select;
   logic atten_bit_16db;
   logic atten_bit_8db;
   logic atten_bit_4db;
   logic atten_bit_2db;
   logic atten_bit_1db;
   logic atten_bit_half_db;
   logic powerup_sel_lo;
   logic powerup_sel_hi;

   modport host (
      output serial_clk, serial_data, latch_strobe, interface_select,
      output atten_bit_16db, atten_bit_8db, atten_bit_4db,
      output atten_bit_2db, atten_bit_1db, atten_bit_half_db,
      output powerup_sel_lo, powerup_sel_hi
   );
   modport device (
      input serial_clk, serial_data, latch_strobe, interface_select,
      input atten_bit_16db, atten_bit_8db, atten_bit_4db,
      input atten_bit_2db, atten_bit_1db, atten_bit_half_db,
      input powerup_sel_lo, powerup_sel_hi
   );
endinterface
`default_nettype wire

// *** hdl/atten_device.sv ***
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - select pin picks parallel or serial word
// - host strobes latched parallel words
// - strobe held high gives direct parallel
// - bits weigh 16 to 0.5 dB
// - six-stage shift register feeds latch
// - shifting ignores the strobe level
// - strobe high passes, falling holds
// - host loads with strobe low, then pulses, unless its direct bit is set
// - serial word msb first, b5 is 16 dB
// - capture on serial clock rising edge
// - strobe rises after last clock fall
// - parallel data stable around strobe
// - serial power-up takes parallel pins
// - parallel power-up, strobe low, uses selects
// - parallel power-up, strobe high, uses pins
module atten_device (
   input  wire logic          CLK,
   input  wire logic          RST_B,
   atten_link_if.device       LINK,
   output logic [5:0]         ATTEN_WORD,
   output logic               ATTEN_16DB,
   output logic               ATTEN_8DB,
   output logic               ATTEN_4DB,
   output logic               ATTEN_2DB,
   output logic               ATTEN_1DB,
   output logic               ATTEN_HALF_DB,
   output logic               INIT_DONE
);

   // power-up table for parallel mode with the strobe low
   function automatic logic [5:0] pup_word(input logic sel_hi, input logic sel_lo);
      logic [5:0] w;
      w = atten_pkg::ATTEN_REF;
      unique case ({sel_hi, sel_lo})
         2'b00: w = atten_pkg::ATTEN_REF;
         2'b01: w = atten_pkg::PUP_8DB;
         2'b10: w = atten_pkg::PUP_16DB;
         2'b11: w = atten_pkg::PUP_31DB;
      endcase
      return w;
   endfunction

   logic [5:0]                shift_q;
   logic [5:0]                shift_m_q;
   logic [5:0]                shift_s_q;
   logic [9:0]                pin_m_q;
   logic [9:0]                pin_s_q;
   logic [5:0]                atten_q;
   logic                      init_done_q;
   atten_pkg::init_state_type state_q;
   logic [9:0]                pins;
   logic [5:0]                par_s;
   logic                      le_s;
   logic                      sel_s;
   logic                      pup_lo_s;
   logic                      pup_hi_s;

   // pins gathered msb first by weight
   assign pins = {LINK.powerup_sel_hi,
                  LINK.powerup_sel_lo,
                  LINK.interface_select,
                  LINK.latch_strobe,
                  LINK.atten_bit_16db,
                  LINK.atten_bit_8db,
                  LINK.atten_bit_4db,
                  LINK.atten_bit_2db,
                  LINK.atten_bit_1db,
                  LINK.atten_bit_half_db};

   // serial shift register on the link clock, strobe not looked at
   always_ff @(posedge LINK.serial_clk or negedge RST_B) begin
      if (!RST_B) begin
         shift_q <= atten_pkg::ATTEN_REF;
      end else begin
         shift_q <= {shift_q[4:0], LINK.serial_data};
      end
   end

   // pin synchronisers, the host pins are asynchronous to CLK
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         pin_m_q <= 10'h000;
         pin_s_q <= 10'h000;
      end else begin
         pin_m_q <= pins;
         pin_s_q <= pin_m_q;
      end
   end

   // shift word crossing; only used while the strobe is high,
   // when the host keeps the register still unless its direct bit is set
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         shift_m_q <= atten_pkg::ATTEN_REF;
         shift_s_q <= atten_pkg::ATTEN_REF;
      end else begin
         shift_m_q <= shift_q;
         shift_s_q <= shift_m_q;
      end
   end

   assign par_s    = pin_s_q[5:0];
   assign le_s     = pin_s_q[6];
   assign sel_s    = pin_s_q[7];
   assign pup_lo_s = pin_s_q[8];
   assign pup_hi_s = pin_s_q[9];

   // power-up sequencer: two cycles for the synchronisers, one load
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         state_q <= atten_pkg::INIT_WAIT0;
      end else begin
         unique case (state_q)
            atten_pkg::INIT_WAIT0: state_q <= atten_pkg::INIT_WAIT1;
            atten_pkg::INIT_WAIT1: state_q <= atten_pkg::INIT_LOAD;
            atten_pkg::INIT_LOAD:  state_q <= atten_pkg::INIT_RUN;
            atten_pkg::INIT_RUN:   state_q <= atten_pkg::INIT_RUN;
         endcase
      end
   end

   // attenuation latch; a level latch emulated at CLK rate,
   // so changes show two or three CLK cycles late
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         atten_q <= atten_pkg::ATTEN_REF;
      end else if (state_q == atten_pkg::INIT_LOAD) begin
         if (sel_s) begin
            atten_q <= par_s;
         end else if (le_s) begin
            atten_q <= par_s;
         end else begin
            atten_q <= pup_word(pup_hi_s, pup_lo_s);
         end
      end else if (state_q == atten_pkg::INIT_RUN) begin
         if (le_s) begin
            // transparent while high, holds once low
            atten_q <= sel_s ? shift_s_q : par_s;
         end
      end
   end

   // marks the end of power-up sampling
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         init_done_q <= 1'b0;
      end else begin
         init_done_q <= (state_q == atten_pkg::INIT_LOAD) ||
                        (state_q == atten_pkg::INIT_RUN);
      end
   end

   // outputs straight from the latch flops
   assign ATTEN_WORD    = atten_q;
   assign ATTEN_16DB    = atten_q[5];
   assign ATTEN_8DB     = atten_q[4];
   assign ATTEN_4DB     = atten_q[3];
   assign ATTEN_2DB     = atten_q[2];
   assign ATTEN_1DB     = atten_q[1];
   assign ATTEN_HALF_DB = atten_q[0];
   assign INIT_DONE     = init_done_q;

endmodule
`default_nettype wire

// *** dv/atten_link_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module atten_link_sva (
   input  wire logic       CLK,
   input  wire logic       RST_B,
   input  wire logic       serial_clk,
   input  wire logic       serial_data,
   input  wire logic       latch_strobe,
   input  wire logic       interface_select,
   input  wire logic       atten_bit_16db,
   input  wire logic       atten_bit_8db,
   input  wire logic       atten_bit_4db,
   input  wire logic       atten_bit_2db,
   input  wire logic       atten_bit_1db,
   input  wire logic       atten_bit_half_db,
   input  wire logic       powerup_sel_lo,
   input  wire logic       powerup_sel_hi,
   input  wire logic [5:0] ATTEN_WORD,
   input  wire logic       INIT_DONE
);
   logic [5:0] pbits;
   logic [5:0] shift_q;
   logic [5:0] pup_word;

   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_B);

   assign pbits = {atten_bit_16db, atten_bit_8db, atten_bit_4db,
                   atten_bit_2db, atten_bit_1db, atten_bit_half_db};

   // reference shifter, msb first, kept apart from the design's own
   always_ff @(posedge serial_clk or negedge RST_B) begin
      if (!RST_B) begin
         shift_q <= 6'h00;
      end else begin
         shift_q <= {shift_q[4:0], serial_data};
      end
   end

   // power-up word expected from the sampled pins
   always_comb begin
      case ({powerup_sel_hi, powerup_sel_lo})
         2'b01:   pup_word = atten_pkg::PUP_8DB;
         2'b10:   pup_word = atten_pkg::PUP_16DB;
         2'b11:   pup_word = atten_pkg::PUP_31DB;
         default: pup_word = atten_pkg::ATTEN_REF;
      endcase
      if (interface_select || latch_strobe) begin
         pup_word = pbits;
      end
   end

   a_clk_quiet_commit: assert property (latch_strobe && interface_select |-> !serial_clk)
      else $error("serial clock high while strobe high");
   a_strobe_after_fall: assert property ($rose(latch_strobe) && interface_select |-> !$past(serial_clk))
      else $error("strobe rose before last clock fall");
   a_data_held_high: assert property (serial_clk |-> $stable(serial_data))
      else $error("serial data moved while clock high");
   // direct mode raises the strobe for good and then moves the bits, so only
   // the strobe edges themselves are held to a still word
   a_par_data_setup: assert property (($rose(latch_strobe) || $fell(latch_strobe)) && !interface_select |-> $stable(pbits))
      else $error("parallel bits moved around strobe");
   // a real latch pulse, two cycles high, not the level held in direct mode
   a_par_word_follow: assert property ($rose(latch_strobe) && !interface_select ##2 !latch_strobe |-> ##2 (ATTEN_WORD == pbits)[*2])
      else $error("parallel word not taken");
   a_serial_commit: assert property ($rose(latch_strobe) && interface_select |-> ##4 (ATTEN_WORD == shift_q)[*3])
      else $error("serial word not passed by latch");
   a_word_hold_low: assert property ((INIT_DONE && !latch_strobe)[*6] |=> $stable(ATTEN_WORD))
      else $error("word changed with strobe low");
   a_powerup_word: assert property ($rose(INIT_DONE) |-> ATTEN_WORD == pup_word)
      else $error("power-up word wrong");
endmodule
`default_nettype wire

// *** dv/step_attenuator_control_port_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module step_attenuator_control_port_tb;
   typedef struct packed {
      logic [3:0] ctrl;
      logic [5:0] data;
      logic [5:0] exp;
   } row_type;
   logic        clk;
   logic        rst_b;
   logic        dev_rst_b;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [5:0]  word;
   logic [5:0]  bits;
   logic        init_done;
   logic [31:0] rd;
   logic        err;
   int          fail_count;
   int          total_checks;
   row_type     rows [13];
   row_type     pups [8];

   atten_link_if link ();

   atten_host u_atten_host (.CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .LINK(link));

   // device gets its own reset so power-up can be replayed with host state kept
   atten_device u_atten_device (.CLK(clk), .RST_B(dev_rst_b), .LINK(link),
      .ATTEN_WORD(word), .ATTEN_16DB(bits[5]), .ATTEN_8DB(bits[4]),
      .ATTEN_4DB(bits[3]), .ATTEN_2DB(bits[2]), .ATTEN_1DB(bits[1]),
      .ATTEN_HALF_DB(bits[0]), .INIT_DONE(init_done));

   atten_link_sva u_atten_link_sva (.CLK(clk), .RST_B(dev_rst_b),
      .serial_clk(link.serial_clk), .serial_data(link.serial_data),
      .latch_strobe(link.latch_strobe), .interface_select(link.interface_select),
      .atten_bit_16db(link.atten_bit_16db), .atten_bit_8db(link.atten_bit_8db),
      .atten_bit_4db(link.atten_bit_4db), .atten_bit_2db(link.atten_bit_2db),
      .atten_bit_1db(link.atten_bit_1db), .atten_bit_half_db(link.atten_bit_half_db),
      .powerup_sel_lo(link.powerup_sel_lo), .powerup_sel_hi(link.powerup_sel_hi),
      .ATTEN_WORD(word), .INIT_DONE(init_done));

   task automatic finish_test;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // one apb transfer; holds the request until pready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (n == 50) begin
         fail_count++;
         finish_test();
      end
   endtask

   // polls busy; a write while busy would be dropped
   task automatic wait_idle;
      int n;
      n = 0;
      do begin
         apb(1'b0, atten_pkg::REG_STATUS, 32'h0);
         n++;
      end while (rd[atten_pkg::STAT_BUSY] !== 1'b0 && n < 100);
      if (n == 100) begin
         fail_count++;
         finish_test();
      end
   endtask

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // hang guard
   initial begin
      repeat (60000) @(posedge clk);
      fail_count++;
      finish_test();
   end

   initial begin
      int n;
      rst_b = 1'b0;
      dev_rst_b = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      fail_count = 0;
      total_checks = 0;
      // ctrl: bit0 serial, bit1 direct, bit2 sel lo, bit3 sel hi
      rows = '{'{4'h0, 6'h01, 6'h01}, '{4'h0, 6'h3f, 6'h3f}, '{4'h0, 6'h00, 6'h00},
               '{4'h1, 6'h20, 6'h20}, '{4'h1, 6'h10, 6'h10}, '{4'h1, 6'h08, 6'h08},
               '{4'h1, 6'h04, 6'h04}, '{4'h1, 6'h02, 6'h02}, '{4'h1, 6'h01, 6'h01},
               '{4'h1, 6'h3f, 6'h3f}, '{4'h1, 6'h15, 6'h15}, '{4'h2, 6'h2a, 6'h2a},
               '{4'h2, 6'h15, 6'h15}};
      pups = '{'{4'h1, 6'h0, 6'h2b}, '{4'h2, 6'h0, 6'h2b}, '{4'h0, 6'h0, 6'h00},
               '{4'h4, 6'h0, 6'h10}, '{4'h8, 6'h0, 6'h20}, '{4'hc, 6'h0, 6'h3e},
               '{4'hd, 6'h0, 6'h2b}, '{4'he, 6'h0, 6'h2b}};
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      dev_rst_b <= 1'b1;
      foreach (rows[i]) begin
         apb(1'b1, atten_pkg::REG_CTRL, {28'h0, rows[i].ctrl});
         apb(1'b1, atten_pkg::REG_DATA, {26'h0, rows[i].data});
         wait_idle();
         check("sent", {26'h0, rd[13:8]}, {26'h0, rows[i].data});
         repeat (6) @(posedge clk);
         check("word", {26'h0, word}, {26'h0, rows[i].exp});
         check("bits", {26'h0, bits}, {26'h0, rows[i].exp});
      end
      // unmapped place: error, reads zero, no effect
      apb(1'b1, 12'h00c, 32'h1);
      check("wr_err", {31'h0, err}, 32'h1);
      apb(1'b0, 12'h00c, 32'h0);
      check("rd_err", {31'h0, err}, 32'h1);
      check("rd_zero", rd, 32'h0);
      // writes during a serial transfer are dropped
      apb(1'b1, atten_pkg::REG_CTRL, 32'h1);
      apb(1'b1, atten_pkg::REG_DATA, 32'h0c);
      apb(1'b1, atten_pkg::REG_DATA, 32'h33);
      apb(1'b1, atten_pkg::REG_CTRL, 32'h0);
      wait_idle();
      repeat (6) @(posedge clk);
      check("busy_word", {26'h0, word}, 32'h0c);
      apb(1'b0, atten_pkg::REG_CTRL, 32'h0);
      check("busy_ctrl", rd, 32'h1);
      // parallel pins hold 2b for the power-up cases
      apb(1'b1, atten_pkg::REG_CTRL, 32'h0);
      apb(1'b1, atten_pkg::REG_DATA, 32'h2b);
      wait_idle();
      foreach (pups[i]) begin
         apb(1'b1, atten_pkg::REG_CTRL, {28'h0, pups[i].ctrl});
         wait_idle();
         dev_rst_b <= 1'b0;
         repeat (2) @(posedge clk);
         dev_rst_b <= 1'b1;
         n = 0;
         while (init_done !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
         end
         @(posedge clk);
         check("powerup", {26'h0, word}, {26'h0, pups[i].exp});
      end
      finish_test();
   end
endmodule
`default_nettype wire
